//--- logic/ulms_top.sv
`timescale 1ns/1ps
`default_nettype none
module ulms_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rx_line,
  output logic tx_line,
  // Transmitter side
  input wire logic tx_serial,
  input wire logic tx_move,
  input wire logic tx_shift_busy,
  input wire logic tx_fifo_empty,
  output logic tx_write,
  output logic [7:0] tx_data,
  // Modem pins
  input wire logic clear_to_send_in_n,
  input wire logic data_set_ready_in_n,
  input wire logic ring_indicator_in_n,
  input wire logic carrier_detect_in_n,
  output logic terminal_ready_out_n,
  output logic request_to_send_ctl_n,
  // Interrupt requests
  output logic rx_data_irq,
  output logic line_status_irq,
  output logic tx_empty_irq,
  output logic modem_status_irq
);
  import ulms_pkg::*;

  // ==========================================
  // Bus decode
  logic [7:0] interrupt_enable, fifo_control, line_config;
  logic [7:0] modem_control;
  logic [15:0] divisor;
  logic [7:0] line_status, modem_status;
  logic [15:0] rd_mux;
  logic mapped;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire rd_setup = setup & ~pwrite;
  wire rd_lsr = rd_setup & (paddr == ADDR_LSR);
  wire rd_msr = rd_setup & (paddr == ADDR_MSR);
  wire fifo_mode = fifo_control[FCR_EN];
  wire loop = modem_control[MCR_LOOP];
  logic [7:0] head_data;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 16'h0000;
    case (paddr)
      ADDR_RXTX: rd_mux = {8'h00, head_data};
      ADDR_IER: rd_mux = {8'h00, interrupt_enable};
      ADDR_FCR: rd_mux = {8'h00, fifo_control};
      ADDR_LCR: rd_mux = {8'h00, line_config};
      ADDR_MCR: rd_mux = {8'h00, modem_control};
      ADDR_LSR: rd_mux = {8'h00, line_status};
      ADDR_MSR: rd_mux = {8'h00, modem_status};
      ADDR_DIV: rd_mux = divisor;
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured at the setup edge, before any clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
      end
    end
  end

  // ==========================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable <= IER_RST;
      fifo_control <= FCR_RST;
      line_config <= LCR_RST;
      modem_control <= MCR_RST;
      divisor <= DIV_RST;
    end else if (wr_en) begin
      case (paddr)
        ADDR_IER: interrupt_enable <= {4'h0, pwdata[3:0]};
        ADDR_FCR: fifo_control <= {7'h00, pwdata[FCR_EN]};
        ADDR_LCR: line_config <= pwdata[7:0];
        ADDR_MCR: modem_control <= {3'h0, pwdata[4:0]};
        ADDR_DIV: divisor <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Host write to the transmit holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_write <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      tx_write <= wr_en & (paddr == ADDR_RXTX);
      if (wr_en && paddr == ADDR_RXTX) begin
        tx_data <= pwdata[7:0];
      end
    end
  end

  // ==========================================
  // 16x sample tick
  logic [15:0] div_cnt;
  logic tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (wr_en && paddr == ADDR_DIV) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt + 16'h0001 >= divisor) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ==========================================
  // Pin synchronisers
  logic rx_meta, rx_sync;
  logic [3:0] modem_meta, modem_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      modem_meta <= MODEM_N_RST;
      modem_sync <= MODEM_N_RST;
    end else begin
      rx_meta <= rx_line;
      rx_sync <= rx_meta;
      modem_meta <= {carrier_detect_in_n, ring_indicator_in_n,
                     data_set_ready_in_n, clear_to_send_in_n};
      modem_sync <= modem_meta;
    end
  end

  // ==========================================
  // Receiver
  ulms_rx_state_e rx_state;
  logic [3:0] tcnt;
  logic [2:0] bcnt;
  logic [7:0] shreg;
  logic par_acc, zero_all, pe_hold;
  logic rx_push;
  logic [10:0] rx_word;
  wire rx_bit = loop ? tx_serial : rx_sync;
  wire sample = tick & (tcnt == TICK_LAST);
  wire [2:0] last_bit = {1'b1, line_config[LCR_WL +: 2]};
  wire [1:0] align = 2'd3 - line_config[LCR_WL +: 2];
  wire par_exp = ~line_config[LCR_EPS];
  wire par_bad = line_config[LCR_STICK] ? (rx_bit != par_exp)
                                        : ((par_acc ^ rx_bit) != par_exp);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      tcnt <= 4'h0;
      bcnt <= 3'h0;
      shreg <= 8'h00;
      par_acc <= 1'b0;
      zero_all <= 1'b0;
      pe_hold <= 1'b0;
      rx_push <= 1'b0;
      rx_word <= 11'h000;
    end else begin
      rx_push <= 1'b0;
      if (tick && rx_state != RX_IDLE) begin
        tcnt <= tcnt + 4'h1;
      end
      case (rx_state)
        RX_IDLE: begin
          tcnt <= 4'h0;
          if (!rx_bit) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick && tcnt == TICK_MID) begin
            tcnt <= 4'h0;
            bcnt <= 3'h0;
            par_acc <= 1'b0;
            zero_all <= 1'b1;
            pe_hold <= 1'b0;
            rx_state <= rx_bit ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (sample) begin
            shreg <= {rx_bit, shreg[7:1]};
            par_acc <= par_acc ^ rx_bit;
            zero_all <= zero_all & ~rx_bit;
            bcnt <= bcnt + 3'h1;
            if (bcnt == last_bit) begin
              rx_state <= line_config[LCR_PEN] ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (sample) begin
            pe_hold <= par_bad;
            zero_all <= zero_all & ~rx_bit;
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (sample) begin
            rx_push <= 1'b1;
            if (zero_all && !rx_bit) begin
              rx_word <= {3'b100, 8'h00};
              tcnt <= 4'h0;
              rx_state <= RX_BREAK;
            end else if (!rx_bit) begin
              rx_word <= {2'b01, pe_hold, shreg >> align};
              tcnt <= 4'h0;
              rx_state <= RX_START;
            end else begin
              rx_word <= {2'b00, pe_hold, shreg >> align};
              rx_state <= RX_IDLE;
            end
          end
        end
        RX_BREAK: begin
          if (!rx_bit) begin
            tcnt <= 4'h0;
          end else if (tick && tcnt == HALF_BIT_LAST) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ==========================================
  // Receive FIFO, depth one outside FIFO mode
  logic [10:0] mem [FIFO_DEPTH];
  logic [3:0] wptr, rptr;
  logic [4:0] count;
  logic [FIFO_DEPTH-1:0] err_vec;
  wire pop = rd_setup & (paddr == ADDR_RXTX) & (count != 5'h00);
  wire full = (fifo_mode ? (count == FIFO_FULL) : (count != 5'h00)) & ~pop;
  wire push_ok = rx_push & ~full;
  wire ovw = rx_push & full & ~fifo_mode;
  wire overrun = rx_push & full;
  wire [3:0] rnext = rptr + 4'h1;
  wire head_in = (push_ok & ((count == 5'h00) | (pop & count == 5'h01))) | ovw;
  wire head_mem = pop & (count > 5'h01);
  wire [2:0] head_err = head_in ? rx_word[10:8] :
                        (head_mem ? mem[rnext][10:8] : 3'b000);
  assign head_data = mem[rptr][7:0];

  always_ff @(posedge pclk) begin
    if (push_ok) begin
      mem[wptr] <= rx_word;
    end else if (ovw) begin
      mem[rptr] <= rx_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      count <= 5'h00;
      err_vec <= '0;
    end else begin
      if (push_ok) begin
        wptr <= wptr + 4'h1;
      end
      if (pop) begin
        rptr <= rnext;
        err_vec[rptr] <= 1'b0;
      end
      if (push_ok) begin
        err_vec[wptr] <= |rx_word[10:8];
      end else if (ovw) begin
        err_vec[rptr] <= |rx_word[10:8];
      end
      if (push_ok && !pop) begin
        count <= count + 5'h01;
      end else if (pop && !push_ok) begin
        count <= count - 5'h01;
      end
    end
  end

  // ==========================================
  // Line status flags
  logic oe_flag, pe_flag, fe_flag, bi_flag, fifo_err_flag;
  logic tx_holding_empty_flag_flag, tx_all_empty_flag_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_flag <= 1'b0;
      pe_flag <= 1'b0;
      fe_flag <= 1'b0;
      bi_flag <= 1'b0;
      fifo_err_flag <= 1'b0;
    end else begin
      oe_flag <= (oe_flag & ~rd_lsr) | overrun;
      pe_flag <= (pe_flag & ~rd_lsr) | head_err[0];
      fe_flag <= (fe_flag & ~rd_lsr) | head_err[1];
      bi_flag <= (bi_flag & ~rd_lsr) | head_err[2];
      fifo_err_flag <= (|err_vec) | (fifo_err_flag & ~rd_lsr);
    end
  end

  // Holding empty: outside FIFO mode a host write refills the register, so it wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_empty_flag_flag <= 1'b1;
      tx_all_empty_flag_flag <= 1'b1;
    end else begin
      if (fifo_mode) begin
        tx_holding_empty_flag_flag <= tx_fifo_empty;
      end else if (tx_write) begin
        tx_holding_empty_flag_flag <= 1'b0;
      end else if (tx_move) begin
        tx_holding_empty_flag_flag <= 1'b1;
      end
      tx_all_empty_flag_flag <= tx_holding_empty_flag_flag & ~tx_shift_busy & ~tx_write;
    end
  end

  assign line_status = {fifo_mode & fifo_err_flag, tx_all_empty_flag_flag, tx_holding_empty_flag_flag,
                        bi_flag, fe_flag, pe_flag, oe_flag,
                        count != 5'h00};

  // ==========================================
  // Modem status
  logic [3:0] modem_prev, modem_delta;
  wire [3:0] modem_n = loop ? ~{modem_control[MCR_USER_OUTPUT_TWO], modem_control[MCR_USER_OUTPUT_ONE],
                                modem_control[MCR_DTR], modem_control[MCR_RTS]}
                            : modem_sync;
  wire [3:0] change = modem_n ^ modem_prev;
  wire [3:0] events = {change[3], ~modem_prev[2] & modem_n[2],
                       change[1], change[0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_prev <= MODEM_N_RST;
      modem_delta <= 4'h0;
    end else begin
      modem_prev <= modem_n;
      modem_delta <= (modem_delta & {4{~rd_msr}}) | events;
    end
  end

  assign modem_status = {~modem_prev, modem_delta};

  // ==========================================
  // Interrupt requests and pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_irq <= 1'b0;
      line_status_irq <= 1'b0;
      tx_empty_irq <= 1'b0;
      modem_status_irq <= 1'b0;
    end else begin
      rx_data_irq <= interrupt_enable[IER_RX] & (count != 5'h00);
      line_status_irq <= interrupt_enable[IER_RLS] &
                         (oe_flag | pe_flag | fe_flag | bi_flag);
      tx_empty_irq <= interrupt_enable[IER_THR] & tx_holding_empty_flag_flag;
      modem_status_irq <= interrupt_enable[IER_MS] & (|modem_delta);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_line <= 1'b1;
      terminal_ready_out_n <= 1'b1;
      request_to_send_ctl_n <= 1'b1;
    end else begin
      tx_line <= loop | tx_serial;
      terminal_ready_out_n <= loop | ~modem_control[MCR_DTR];
      request_to_send_ctl_n <= loop | ~modem_control[MCR_RTS];
    end
  end
endmodule
`default_nettype wire

//--- inc/ulms_pkg.sv
`default_nettype none
package ulms_pkg;
  // ==========================================
  // Register indices and byte addresses
  localparam int IDX_RXTX = 0;
  localparam int IDX_IER = 1;
  localparam int IDX_FCR = 2;
  localparam int IDX_LCR = 3;
  localparam int IDX_MCR = 4;
  localparam int IDX_LSR = 5;
  localparam int IDX_MSR = 6;
  localparam int IDX_DIV = 7;
  localparam logic [5:0] ADDR_RXTX = 6'(4 * IDX_RXTX);
  localparam logic [5:0] ADDR_IER = 6'(4 * IDX_IER);
  localparam logic [5:0] ADDR_FCR = 6'(4 * IDX_FCR);
  localparam logic [5:0] ADDR_LCR = 6'(4 * IDX_LCR);
  localparam logic [5:0] ADDR_MCR = 6'(4 * IDX_MCR);
  localparam logic [5:0] ADDR_LSR = 6'(4 * IDX_LSR);
  localparam logic [5:0] ADDR_MSR = 6'(4 * IDX_MSR);
  localparam logic [5:0] ADDR_DIV = 6'(4 * IDX_DIV);
  // ==========================================
  // Field positions
  localparam int IER_RX = 0;
  localparam int IER_THR = 1;
  localparam int IER_RLS = 2;
  localparam int IER_MS = 3;
  localparam int FCR_EN = 0;
  localparam int LCR_WL = 0;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_USER_OUTPUT_ONE = 2;
  localparam int MCR_USER_OUTPUT_TWO = 3;
  localparam int MCR_LOOP = 4;
  // ==========================================
  // Reset values
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h03;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0036;
  localparam logic [3:0] MODEM_N_RST = 4'hf;
  // ==========================================
  // Timing in 16x ticks and FIFO shape
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] HALF_BIT_LAST = 4'h7;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  typedef enum {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK
  } ulms_rx_state_e;
endpackage
`default_nettype wire

//--- bench/ulms_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ulms_checker
  import ulms_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial and transmitter
  input wire logic tx_line,
  input wire logic tx_serial,
  input wire logic tx_shift_busy,
  input wire logic tx_fifo_empty,
  // Modem
  input wire logic clear_to_send_in_n,
  input wire logic data_set_ready_in_n,
  input wire logic ring_indicator_in_n,
  input wire logic carrier_detect_in_n,
  input wire logic terminal_ready_out_n,
  input wire logic request_to_send_ctl_n,
  // Requests
  input wire logic rx_data_irq,
  input wire logic line_status_irq,
  input wire logic tx_empty_irq,
  input wire logic modem_status_irq
);
  logic [7:0] ier_q, ier_d, mcr_q;
  logic loop_d, fifo_q, fifo_ever;
  logic [3:0] mdm_q;
  logic [2:0] quiet;
  logic acc_wr, rd_lsr, rd_msr;
  assign acc_wr = psel && penable && pready && pwrite;
  assign rd_lsr = psel && !penable && !pwrite && paddr == ADDR_LSR;
  assign rd_msr = psel && !penable && !pwrite && paddr == ADDR_MSR;
  // ==========================================
  // Shadow of control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_q <= IER_RST;
      ier_d <= IER_RST;
      mcr_q <= MCR_RST;
      loop_d <= 1'b0;
      fifo_q <= 1'b0;
      fifo_ever <= 1'b0;
    end else begin
      ier_d <= ier_q;
      loop_d <= mcr_q[MCR_LOOP];
      if (acc_wr && paddr == ADDR_IER) ier_q <= pwdata[7:0];
      if (acc_wr && paddr == ADDR_MCR) mcr_q <= pwdata[7:0];
      if (acc_wr && paddr == ADDR_FCR) fifo_q <= pwdata[FCR_EN];
      if (acc_wr && paddr == ADDR_FCR && pwdata[FCR_EN]) fifo_ever <= 1'b1;
    end
  end
  // ==========================================
  // Cycles since a modem input last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdm_q <= MODEM_N_RST;
      quiet <= 3'h0;
    end else begin
      mdm_q <= {carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n};
      if (mdm_q != {carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n}) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_UNMAPPED: assert property (psel && !penable && paddr[5] |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_TX_PASS: assert property (!mcr_q[MCR_LOOP] && !loop_d |-> tx_line == $past(tx_serial))
    else $error("transmit line not following shifter");
  AST_TX_LOOP: assert property (mcr_q[MCR_LOOP] && loop_d |-> tx_line && terminal_ready_out_n && request_to_send_ctl_n)
    else $error("loopback pins not idle");
  AST_MSR_LEVEL: assert property (rd_msr && quiet >= 3'h4 && !mcr_q[MCR_LOOP] && !loop_d |=>
    prdata[7:4] == ~{carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n})
    else $error("modem levels wrong");
  AST_MSR_LOOP: assert property (rd_msr && mcr_q[MCR_LOOP] && loop_d |=>
    prdata[7:4] == $past({mcr_q[MCR_USER_OUTPUT_TWO], mcr_q[MCR_USER_OUTPUT_ONE], mcr_q[MCR_DTR], mcr_q[MCR_RTS]}, 2))
    else $error("loopback modem levels wrong");
  AST_TX_ALL_EMPTY_FLAG: assert property (rd_lsr && tx_shift_busy && $past(tx_shift_busy) |=> !prdata[6])
    else $error("transmitter empty while shifting");
  AST_BIT7: assert property (rd_lsr && !fifo_ever |=> !prdata[7]) else $error("error summary outside fifo mode");
  AST_THR_SET: assert property ((fifo_q && ier_q[IER_THR] && tx_fifo_empty) [*3] |-> tx_empty_irq)
    else $error("no transmit request on empty fifo");
  AST_THR_CLR: assert property ((fifo_q && !tx_fifo_empty) [*3] |-> !tx_empty_irq)
    else $error("transmit request with filled fifo");
  AST_MODEM_IRQ: assert property (($changed(clear_to_send_in_n) || $changed(data_set_ready_in_n) ||
    $changed(carrier_detect_in_n) || $rose(ring_indicator_in_n)) && ier_q[IER_MS] && !mcr_q[MCR_LOOP]
    |-> ##[1:8] modem_status_irq) else $error("modem request missing");
  AST_IRQ_MASK: assert property (!((rx_data_irq && !ier_q[IER_RX] && !ier_d[IER_RX]) ||
    (line_status_irq && !ier_q[IER_RLS] && !ier_d[IER_RLS]) || (tx_empty_irq && !ier_q[IER_THR] && !ier_d[IER_THR])
    || (modem_status_irq && !ier_q[IER_MS] && !ier_d[IER_MS]))) else $error("masked request raised");
  cover property (rd_lsr ##1 prdata[1]);
  cover property ($rose(modem_status_irq));
  cover property (rd_msr && mcr_q[MCR_LOOP] && loop_d);
  cover property (fifo_q && tx_empty_irq);
endmodule
bind ulms_top ulms_checker ulms_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_line(tx_line), .tx_serial(tx_serial), .tx_shift_busy(tx_shift_busy), .tx_fifo_empty(tx_fifo_empty),
  .clear_to_send_in_n(clear_to_send_in_n), .data_set_ready_in_n(data_set_ready_in_n),
  .ring_indicator_in_n(ring_indicator_in_n), .carrier_detect_in_n(carrier_detect_in_n),
  .terminal_ready_out_n(terminal_ready_out_n), .request_to_send_ctl_n(request_to_send_ctl_n),
  .rx_data_irq(rx_data_irq), .line_status_irq(line_status_irq), .tx_empty_irq(tx_empty_irq),
  .modem_status_irq(modem_status_irq));
`default_nettype wire

//--- bench/ulms_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ulms_modem_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire logic pclk,
  // Lines toward the port
  output logic rx_line,
  output logic clear_to_send_in_n,
  output logic data_set_ready_in_n,
  output logic ring_indicator_in_n,
  output logic carrier_detect_in_n
);
  initial begin
    rx_line = 1'b1;
    {carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n} = 4'hf;
  end
  // ==========================================
  // Bits leave LSB first; a full marking bit follows every burst
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge pclk);
  endtask
  task automatic lines(input logic [3:0] v);
    {carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n} <= v;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- bench/ulms_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ulms_top_tb;
  import ulms_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, tx_line, tx_serial, tx_move;
  logic tx_shift_busy, tx_fifo_empty, tx_write, cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, i_rx, i_ls, i_tx, i_ms;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] tx_data;
  logic [10:0] lf;
  int bad_count, comparisons;
  logic [5:0] ra[7] = '{ADDR_LSR, ADDR_MSR, ADDR_IER, ADDR_LCR, ADDR_MCR, ADDR_DIV, 6'h20};
  logic [7:0] rv[7] = '{8'h60, 8'h00, 8'h00, 8'h03, 8'h00, 8'h36, 8'h00};
  ulms_top ulms_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
    .tx_line(tx_line), .tx_serial(tx_serial), .tx_move(tx_move), .tx_shift_busy(tx_shift_busy),
    .tx_fifo_empty(tx_fifo_empty), .tx_write(tx_write), .tx_data(tx_data), .clear_to_send_in_n(cts_n),
    .data_set_ready_in_n(dsr_n), .ring_indicator_in_n(ri_n), .carrier_detect_in_n(dcd_n),
    .terminal_ready_out_n(dtr_n), .request_to_send_ctl_n(rts_n), .rx_data_irq(i_rx), .line_status_irq(i_ls),
    .tx_empty_irq(i_tx), .modem_status_irq(i_ms));
  ulms_modem_model #(.BIT_CLKS(16)) ulms_modem_model_inst (.pclk(pclk), .rx_line(rx_line),
    .clear_to_send_in_n(cts_n), .data_set_ready_in_n(dsr_n), .ring_indicator_in_n(ri_n),
    .carrier_detect_in_n(dcd_n));
  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 32'(pready), 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), q & {24'hffffff, m}, {24'h0, x & m});
    chk("pslverr", 32'(e), 32'(a[5]));
  endtask
  task automatic rx(input logic [7:0] d, input logic pbad, input logic stp);
    ulms_modem_model_inst.send({21'h0, stp, ^d ^ pbad, d, 1'b0}, 11);
  endtask
  task automatic md(input logic [3:0] v);
    ulms_modem_model_inst.lines(v);
    cyc(10);
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #500000;
    bad_count++;
    close_out();
  end
  // ==========================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, tx_move, tx_shift_busy} = 6'h0;
    {paddr, pwdata, tx_serial, tx_fifo_empty} = {38'h0, 2'b11};
    bad_count = 0;
    comparisons = 0;
    cyc(8);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i]) rd(ra[i], 8'hff, rv[i]);
    wr(ADDR_LSR, 32'hff);
    wr(ADDR_DIV, 32'h1);
    wr(ADDR_LCR, 32'h1b);
    wr(ADDR_IER, 32'h0f);
    rd(ADDR_LSR, 8'hff, 8'h60);
    rx(8'ha5, 1'b0, 1'b1);
    chk("rx_data_irq", 32'(i_rx), 32'h1);
    rd(ADDR_LSR, 8'hff, 8'h61);
    rd(ADDR_RXTX, 8'hff, 8'ha5);
    rd(ADDR_LSR, 8'hff, 8'h60);
    rx(8'h3c, 1'b0, 1'b1);
    rx(8'h5a, 1'b0, 1'b1);
    chk("line_status_irq", 32'(i_ls), 32'h1);
    rd(ADDR_LSR, 8'hff, 8'h63);
    rd(ADDR_LSR, 8'hff, 8'h61);
    cyc(2);
    chk("line_status_irq", 32'(i_ls), 32'h0);
    rd(ADDR_RXTX, 8'hff, 8'h5a);
    rx(8'ha5, 1'b1, 1'b1);
    rd(ADDR_LSR, 8'hff, 8'h65);
    rd(ADDR_RXTX, 8'hff, 8'ha5);
    rx(8'ha5, 1'b0, 1'b0);
    rd(ADDR_LSR, 8'hff, 8'h69);
    rd(ADDR_RXTX, 8'hff, 8'ha5);
    rd(ADDR_LSR, 8'hff, 8'h60);
    ulms_modem_model_inst.send(32'h0, 30);
    rd(ADDR_LSR, 8'hff, 8'h71);
    rd(ADDR_RXTX, 8'hff, 8'h00);
    rd(ADDR_LSR, 8'hff, 8'h60);
    wr(ADDR_RXTX, 32'h3c);
    #1;
    chk("tx_write", 32'(tx_write), 32'h1);
    chk("tx_data", 32'(tx_data), 32'h3c);
    rd(ADDR_LSR, 8'hff, 8'h00);
    chk("tx_empty_irq", 32'(i_tx), 32'h0);
    tx_move <= 1'b1;
    tx_shift_busy <= 1'b1;
    @(posedge pclk);
    tx_move <= 1'b0;
    cyc(2);
    rd(ADDR_LSR, 8'hff, 8'h20);
    chk("tx_empty_irq", 32'(i_tx), 32'h1);
    tx_shift_busy <= 1'b0;
    cyc(2);
    rd(ADDR_LSR, 8'hff, 8'h60);
    md(4'b1110);
    chk("modem_status_irq", 32'(i_ms), 32'h1);
    rd(ADDR_MSR, 8'hff, 8'h11);
    rd(ADDR_MSR, 8'hff, 8'h10);
    cyc(2);
    chk("modem_status_irq", 32'(i_ms), 32'h0);
    md(4'b1010);
    rd(ADDR_MSR, 8'hff, 8'h50);
    md(4'b1110);
    rd(ADDR_MSR, 8'hff, 8'h14);
    md(4'b0100);
    rd(ADDR_MSR, 8'hff, 8'hba);
    wr(ADDR_IER, 32'h0);
    md(4'b1100);
    chk("modem_status_irq", 32'(i_ms), 32'h0);
    rd(ADDR_MSR, 8'hff, 8'h38);
    wr(ADDR_IER, 32'h0f);
    wr(ADDR_FCR, 32'h1);
    tx_fifo_empty <= 1'b0;
    cyc(3);
    rd(ADDR_LSR, 8'hff, 8'h00);
    chk("tx_empty_irq", 32'(i_tx), 32'h0);
    tx_fifo_empty <= 1'b1;
    cyc(3);
    rd(ADDR_LSR, 8'hff, 8'h60);
    for (int i = 0; i < 17; i++) rx(8'(i), 1'b0, 1'b1);
    rd(ADDR_LSR, 8'hff, 8'h63);
    for (int i = 0; i < 16; i++) rd(ADDR_RXTX, 8'hff, 8'(i));
    rd(ADDR_LSR, 8'hff, 8'h60);
    rx(8'h11, 1'b0, 1'b1);
    rx(8'h22, 1'b1, 1'b1);
    rd(ADDR_LSR, 8'hff, 8'he1);
    rd(ADDR_RXTX, 8'hff, 8'h11);
    rd(ADDR_LSR, 8'hff, 8'he5);
    rd(ADDR_RXTX, 8'hff, 8'h22);
    rd(ADDR_LSR, 8'hff, 8'he0);
    rd(ADDR_LSR, 8'hff, 8'h60);
    wr(ADDR_MCR, 32'h03);
    cyc(2);
    chk("modem pins", {30'h0, dtr_n, rts_n}, 32'h0);
    wr(ADDR_MCR, 32'h1d);
    cyc(3);
    rd(ADDR_MSR, 8'hf0, 8'he0);
    lf = {1'b1, ^8'h96, 8'h96, 1'b0};
    for (int i = 0; i < 12; i++) begin
      tx_serial <= (i < 11) ? lf[i] : 1'b1;
      cyc(16);
      chk("tx_line", 32'(tx_line), 32'h1);
    end
    rd(ADDR_RXTX, 8'hff, 8'h96);
    close_out();
  end
endmodule
`default_nettype wire
